// [hw/mmsd_decoder.sv]
// Memory space decoder top: routes core data and program accesses.
// Assumes the core sits on clk_i and holds its request until answered.
//
// What this block does
// - Internal data space is 256 bytes.
// - Indirect upper-half accesses reach RAM.
// - Direct upper-half accesses reach special registers.
// - Lower half same RAM either mode.
// - Lowest 32 bytes form four register banks.
// - Next 16 bytes are byte and bit addressable.
// - Program space is 64k or 32k bytes.
// - Flash reprogramming works on 512-byte sectors.
// - 0xFC00 to 0xFFFF reserved on 64k parts.
// - External data RAM is 4k or 2k.
// - Separate 1k USB FIFO RAM always present.
`timescale 1ns/1ps
`default_nettype none
`include "mmsd_defines.svh"
module mmsd_decoder
  import mmsd_pkg::*;
#(
  parameter bit FLASH_64K = 1'b1
)
(
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Internal data request.
  input  wire logic         id_req_i,
  input  wire logic [7:0]   id_addr_i,
  input  wire logic         id_indirect_i,
  input  wire logic         id_bit_i,
  input  wire logic         id_reg_i,
  input  wire logic [1:0]   psw_bank_i,
  // External data request.
  input  wire logic         xd_req_i,
  input  wire logic [15:0]  xd_addr_i,
  input  wire logic         xd_usb_i,
  // Program request.
  input  wire logic         pm_req_i,
  input  wire logic [15:0]  pm_addr_i,
  input  wire logic         pm_erase_i,
  // Internal data result.
  output logic              id_valid_o,
  output mmsd_target_t      id_target_o,
  output logic [7:0]        id_ram_addr_o,
  output logic [2:0]        id_bit_o,
  output logic              id_bank_o,
  output logic              id_bitarea_o,
  // External data result.
  output logic              xd_valid_o,
  output mmsd_target_t      xd_target_o,
  output logic [11:0]       xd_ram_addr_o,
  output logic [9:0]        xd_fifo_addr_o,
  // Program result.
  output logic              pm_valid_o,
  output mmsd_target_t      pm_target_o,
  output logic [15:0]       pm_flash_addr_o,
  output logic [6:0]        pm_sector_o,
  output logic              pm_sector_erase_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_s1_q;
  logic rst_s1_d;
  logic rst_s2_q;
  logic rst_s2_d;
  logic rst_n;

  // A one walks in from the first stage to the second once the pin lets go.
  always_comb begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  // Two stages release the asynchronous reset cleanly; the pin clears both at once.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  // Every other register is cleared by this copy. Entry into reset stays
  // asynchronous, but leaving it always lines up with a clock edge.
  assign rst_n = rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Size helpers.
  // Both helpers take the variant as an argument so that one parameter
  // sets the program and the external data limits together.

  // Returns one when the program address is usable on this variant. On the large
  // part the top kilobyte is held back, so a fetch there answers with no target
  // rather than wrapping into user code.
  function automatic logic pm_ok(input logic [15:0] a, input logic big);
    logic ok;
    ok = 1'b0;
    if (big) begin
      ok = a < `MMSD_RSVD_BASE;
    end else begin
      ok = {1'b0, a} < `MMSD_FLASH_32K;
    end
    return ok;
  endfunction : pm_ok

  // Size of the on-chip external data RAM for a variant. It follows the
  // flash size, so the two can never disagree.
  function automatic logic [15:0] xdata_ram_size(input logic big);
    return big ? `MMSD_ONCHIP_EXTERNAL_DATA_RAM_4K : `MMSD_ONCHIP_EXTERNAL_DATA_RAM_2K;
  endfunction : xdata_ram_size

  ////////////////////////////////////////////////////////////////////////////
  // Internal data mapping.
  // A working register access wins over a bit access, which wins over a plain
  // byte access. Only a direct upper-half byte or bit reaches the special registers;
  // the same address taken indirectly lands in general purpose RAM.

  logic       map_special;
  logic [7:0] map_addr;
  logic       map_bank;
  logic       map_bitarea;

  // The mapper is pure logic; its answer is captured with the request below, so
  // the result ports never show a half-decoded address.
  mmsd_idata_map u_map (
    .addr_i                               (id_addr_i),
    .indirect_i                           (id_indirect_i),
    .bit_mode_i                           (id_bit_i),
    .bank_sel_i                           (psw_bank_i),
    .reg_mode_i                           (id_reg_i),
    .is_special_function_register_space_o (map_special),
    .ram_addr_o                           (map_addr),
    .in_bank_o                            (map_bank),
    .in_bitarea_o                         (map_bitarea)
  );

  logic         id_valid_q, id_valid_d;
  mmsd_target_t id_target_q, id_target_d;
  logic [7:0]   id_ram_q, id_ram_d;
  logic [2:0]   id_bit_q, id_bit_d;
  logic         id_bank_q, id_bank_d;
  logic         id_bitarea_q, id_bitarea_d;

  // Internal data results for the next cycle. Valid and target last one cycle
  // per request; the address fields hold until the next request replaces them.
  always_comb begin
    id_valid_d   = id_req_i;
    id_target_d  = MMSD_T_NONE;
    id_ram_d     = id_ram_q;
    id_bit_d     = id_bit_q;
    id_bank_d    = id_bank_q;
    id_bitarea_d = id_bitarea_q;
    if (id_req_i) begin
      id_target_d  = map_special ? MMSD_T_SPECIAL_FUNCTION_REGISTER_SPACE : MMSD_T_IRAM;
      id_ram_d     = map_addr;
      id_bit_d     = id_bit_i ? id_addr_i[2:0] : 3'h0;
      id_bank_d    = map_bank;
      id_bitarea_d = map_bitarea;
    end
  end

  // Internal data result registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      id_valid_q   <= 1'b0;
      id_target_q  <= MMSD_T_NONE;
      id_ram_q     <= 8'h00;
      id_bit_q     <= 3'h0;
      id_bank_q    <= 1'b0;
      id_bitarea_q <= 1'b0;
    end else begin
      id_valid_q   <= id_valid_d;
      id_target_q  <= id_target_d;
      id_ram_q     <= id_ram_d;
      id_bit_q     <= id_bit_d;
      id_bank_q    <= id_bank_d;
      id_bitarea_q <= id_bitarea_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External data mapping.
  // The USB flag picks a space of its own, so a FIFO offset never aliases
  // the on-chip external data RAM at the same address.

  logic         xd_valid_q, xd_valid_d;
  mmsd_target_t xd_target_q, xd_target_d;
  logic [11:0]  xd_ram_q, xd_ram_d;
  logic [9:0]   xd_fifo_q, xd_fifo_d;

  // USB FIFO is its own space; RAM size follows the variant.
  // An address past the end answers with no target and leaves the held
  // address fields as they were.
  always_comb begin
    xd_valid_d  = xd_req_i;
    xd_target_d = MMSD_T_NONE;
    xd_ram_d    = xd_ram_q;
    xd_fifo_d   = xd_fifo_q;
    if (xd_req_i && xd_usb_i) begin
      if (xd_addr_i < `MMSD_USB_FIFO_SIZE) begin
        xd_target_d = MMSD_T_USB_FIFO;
        xd_fifo_d   = xd_addr_i[9:0];
      end
    end else if (xd_req_i) begin
      if (xd_addr_i < xdata_ram_size(FLASH_64K)) begin
        xd_target_d = MMSD_T_ONCHIP_EXTERNAL_DATA_RAM;
        xd_ram_d    = xd_addr_i[11:0];
      end
    end
  end

  // External data result registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xd_valid_q  <= 1'b0;
      xd_target_q <= MMSD_T_NONE;
      xd_ram_q    <= 12'h000;
      xd_fifo_q   <= 10'h000;
    end else begin
      xd_valid_q  <= xd_valid_d;
      xd_target_q <= xd_target_d;
      xd_ram_q    <= xd_ram_d;
      xd_fifo_q   <= xd_fifo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program space mapping.
  // Sector numbers are the upper address bits, so an erase always covers
  // one aligned 512-byte block and never straddles two.

  logic         pm_valid_q, pm_valid_d;
  mmsd_target_t pm_target_q, pm_target_d;
  logic [15:0]  pm_addr_q, pm_addr_d;
  logic [6:0]   pm_sector_q, pm_sector_d;
  logic         pm_erase_q, pm_erase_d;

  // Reserved or absent addresses answer with no target.
  // The erase flag is dropped for them, so a stray erase cannot reach the
  // reserved top or memory that this variant lacks.
  always_comb begin
    pm_valid_d  = pm_req_i;
    pm_target_d = MMSD_T_NONE;
    pm_addr_d   = pm_addr_q;
    pm_sector_d = pm_sector_q;
    pm_erase_d  = 1'b0;
    if (pm_req_i && pm_ok(pm_addr_i, FLASH_64K)) begin
      pm_target_d = MMSD_T_CODE;
      pm_addr_d   = pm_addr_i;
      pm_sector_d = pm_addr_i[15:`MMSD_SECTOR_SHIFT];
      pm_erase_d  = pm_erase_i;
    end
  end

  // Program result registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pm_valid_q  <= 1'b0;
      pm_target_q <= MMSD_T_NONE;
      pm_addr_q   <= 16'h0000;
      pm_sector_q <= 7'h00;
      pm_erase_q  <= 1'b0;
    end else begin
      pm_valid_q  <= pm_valid_d;
      pm_target_q <= pm_target_d;
      pm_addr_q   <= pm_addr_d;
      pm_sector_q <= pm_sector_d;
      pm_erase_q  <= pm_erase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // All results come straight from flip-flops.
  // The core therefore sees stable values for a whole cycle after each edge
  // and needs no settling margin of its own.
  assign id_valid_o        = id_valid_q;
  assign id_target_o       = id_target_q;
  assign id_ram_addr_o     = id_ram_q;
  assign id_bit_o          = id_bit_q;
  assign id_bank_o         = id_bank_q;
  assign id_bitarea_o      = id_bitarea_q;
  assign xd_valid_o        = xd_valid_q;
  assign xd_target_o       = xd_target_q;
  assign xd_ram_addr_o     = xd_ram_q;
  assign xd_fifo_addr_o    = xd_fifo_q;
  assign pm_valid_o        = pm_valid_q;
  assign pm_target_o       = pm_target_q;
  assign pm_flash_addr_o   = pm_addr_q;
  assign pm_sector_o       = pm_sector_q;
  assign pm_sector_erase_o = pm_erase_q;

endmodule : mmsd_decoder
`default_nettype wire

// [hw/mmsd_defines.svh]
// Address map constants for the memory space decoder.
// Assumes inclusion by bare name from design files.
`ifndef MMSD_DEFINES_SVH
`define MMSD_DEFINES_SVH
`define MMSD_IDATA_SIZE      16'h0100
`define MMSD_IDATA_HALF      8'h80
`define MMSD_BANK_BYTES      8'h20
`define MMSD_BANK_REGS       8'h08
`define MMSD_BIT_BASE        8'h20
`define MMSD_BIT_END         8'h30
`define MMSD_FLASH_64K       17'h10000
`define MMSD_FLASH_32K       17'h08000
`define MMSD_SECTOR_SHIFT    9
`define MMSD_RSVD_BASE       16'hfc00
`define MMSD_ONCHIP_EXTERNAL_DATA_RAM_4K 16'h1000
`define MMSD_ONCHIP_EXTERNAL_DATA_RAM_2K 16'h0800
`define MMSD_USB_FIFO_SIZE   16'h0400
`endif

// [hw/mmsd_pkg.sv]
// Types shared by the memory space decoder files.
// Assumes nothing of its surroundings.
package mmsd_pkg;
  typedef enum logic [2:0] {
    MMSD_T_NONE,
    MMSD_T_IRAM,
    MMSD_T_SPECIAL_FUNCTION_REGISTER_SPACE,
    MMSD_T_ONCHIP_EXTERNAL_DATA_RAM,
    MMSD_T_USB_FIFO,
    MMSD_T_CODE
  } mmsd_target_t;
endpackage : mmsd_pkg

// [hw/mmsd_idata_map.sv]
// Internal data space mapper: direct or indirect 8-bit address to target.
// Assumes combinational use inside the decoder top on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "mmsd_defines.svh"
module mmsd_idata_map
  import mmsd_pkg::*;
(
  // Access request.
  input  wire logic [7:0]   addr_i,
  input  wire logic         indirect_i,
  input  wire logic         bit_mode_i,
  input  wire logic [1:0]   bank_sel_i,
  input  wire logic         reg_mode_i,
  // Routing result.
  output logic              is_special_function_register_space_o,
  output logic [7:0]        ram_addr_o,
  output logic              in_bank_o,
  output logic              in_bitarea_o
);
  logic [7:0] byte_addr;

  // Bit addresses below 0x80 pick a byte in the bit-addressable area.
  always_comb begin
    byte_addr = addr_i;
    if (reg_mode_i) begin
      byte_addr = {3'h0, bank_sel_i, addr_i[2:0]};
    end else if (bit_mode_i && !addr_i[7]) begin
      byte_addr = `MMSD_BIT_BASE + {4'h0, addr_i[6:3]};
    end else if (bit_mode_i) begin
      byte_addr = {addr_i[7:3], 3'h0};
    end
    is_special_function_register_space_o = byte_addr[7] && !indirect_i && !reg_mode_i;
    ram_addr_o   = byte_addr;
    in_bank_o    = byte_addr < `MMSD_BANK_BYTES;
    in_bitarea_o = (byte_addr >= `MMSD_BIT_BASE) && (byte_addr < `MMSD_BIT_END);
  end
endmodule : mmsd_idata_map
`default_nettype wire

// [verification/mmsd_decoder_checker.sv]
// Concurrent checks on the memory space decoder ports.
// Assumes it is bound to every decoder instance and requests start after reset release.
`timescale 1ns/1ps
`default_nettype none
module mmsd_checker
  import mmsd_pkg::*;
#(
  parameter bit FLASH_64K = 1'b1
)
(
  // Clock and reset.
  input wire logic         clk_i,
  input wire logic         resetn_i,
  // Requests.
  input wire logic         id_req_i,
  input wire logic [7:0]   id_addr_i,
  input wire logic         id_indirect_i,
  input wire logic         id_bit_i,
  input wire logic         id_reg_i,
  input wire logic [1:0]   psw_bank_i,
  input wire logic         xd_req_i,
  input wire logic [15:0]  xd_addr_i,
  input wire logic         xd_usb_i,
  input wire logic         pm_req_i,
  input wire logic [15:0]  pm_addr_i,
  input wire logic         pm_erase_i,
  // Results.
  input wire logic         id_valid_o,
  input wire mmsd_target_t id_target_o,
  input wire logic [7:0]   id_ram_addr_o,
  input wire logic [2:0]   id_bit_o,
  input wire logic         id_bank_o,
  input wire mmsd_target_t xd_target_o,
  input wire logic [11:0]  xd_ram_addr_o,
  input wire logic [9:0]   xd_fifo_addr_o,
  input wire mmsd_target_t pm_target_o,
  input wire logic [6:0]   pm_sector_o,
  input wire logic         pm_sector_erase_o
);
  // Variant limits for external data and program space.
  localparam logic [16:0] PM_LIM = FLASH_64K ? 17'h0fc00 : 17'h08000;
  localparam logic [16:0] XR_LIM = FLASH_64K ? 17'h01000 : 17'h00800;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  // Each result ties to the request sampled one edge earlier.
  a_id_valid_once: assert property (id_req_i |=> id_valid_o ##1 (id_valid_o == $past(id_req_i)))
    else $error("id valid timing wrong");
  a_direct_to_special: assert property (id_req_i && id_addr_i[7] && !id_indirect_i && !id_reg_i
    |=> id_target_o == MMSD_T_SPECIAL_FUNCTION_REGISTER_SPACE)
    else $error("direct upper access not routed to register space");
  a_indirect_to_ram: assert property (id_req_i && id_addr_i[7] && id_indirect_i && !id_bit_i && !id_reg_i
    |=> id_target_o == MMSD_T_IRAM && id_ram_addr_o == $past(id_addr_i)) else $error("indirect upper access wrong");
  a_low_half_same: assert property (id_req_i && !id_addr_i[7] && !id_bit_i && !id_reg_i
    |=> id_target_o == MMSD_T_IRAM && id_ram_addr_o == $past(id_addr_i)) else $error("lower half access wrong");
  a_reg_bank_sel: assert property (id_req_i && id_reg_i |=> id_bank_o && id_target_o == MMSD_T_IRAM
    && id_ram_addr_o == {3'b000, $past(psw_bank_i), $past(id_addr_i[2:0])}) else $error("register bank access wrong");
  a_bit_area_map: assert property (id_req_i && id_bit_i && !id_reg_i && !id_addr_i[7]
    |=> id_bit_o == $past(id_addr_i[2:0]) && id_ram_addr_o == 8'h20 + {4'h0, $past(id_addr_i[6:3])})
    else $error("bit area mapping wrong");
  a_external_ram_range: assert property (xd_req_i && !xd_usb_i
    |=> (xd_target_o == MMSD_T_ONCHIP_EXTERNAL_DATA_RAM) == ($past(xd_addr_i) < XR_LIM))
    else $error("external data range wrong");
  a_fifo_route: assert property (xd_req_i && xd_usb_i && xd_addr_i < 16'h0400
    |=> xd_target_o == MMSD_T_USB_FIFO && xd_fifo_addr_o == $past(xd_addr_i[9:0]))
    else $error("fifo access wrong");
  a_pm_reserved: assert property (pm_req_i && pm_addr_i >= PM_LIM |=> pm_target_o == MMSD_T_NONE
    && !pm_sector_erase_o) else $error("reserved program access accepted");
  a_pm_sector: assert property (pm_req_i && pm_addr_i < PM_LIM |=> pm_target_o == MMSD_T_CODE
    && pm_sector_o == $past(pm_addr_i[15:9]) && pm_sector_erase_o == $past(pm_erase_i)) else $error("sector wrong");
endmodule : mmsd_checker
bind mmsd_decoder mmsd_checker #(.FLASH_64K(FLASH_64K)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .id_req_i(id_req_i), .id_addr_i(id_addr_i), .id_indirect_i(id_indirect_i), .id_bit_i(id_bit_i),
  .id_reg_i(id_reg_i), .psw_bank_i(psw_bank_i), .xd_req_i(xd_req_i), .xd_addr_i(xd_addr_i), .xd_usb_i(xd_usb_i),
  .pm_req_i(pm_req_i), .pm_addr_i(pm_addr_i), .pm_erase_i(pm_erase_i), .id_valid_o(id_valid_o),
  .id_target_o(id_target_o), .id_ram_addr_o(id_ram_addr_o), .id_bit_o(id_bit_o), .id_bank_o(id_bank_o),
  .xd_target_o(xd_target_o), .xd_ram_addr_o(xd_ram_addr_o), .xd_fifo_addr_o(xd_fifo_addr_o),
  .pm_target_o(pm_target_o), .pm_sector_o(pm_sector_o), .pm_sector_erase_o(pm_sector_erase_o));
`default_nettype wire

// [verification/mmsd_core_model.sv]
// Processor core model issuing one decoder request at a time.
// Assumes the caller waits for reset release; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module mmsd_core_model (
  // Clock.
  input  wire logic        clk_i,
  // Request flags {id_req, indirect, bit, reg, xd_req, usb, pm_req, erase}.
  output logic [7:0]       ctl_o,
  // Shared address and bank select.
  output logic [15:0]      addr_o,
  output logic [1:0]       bank_o
);
  // Lines start idle so no request leaks out of reset.
  initial begin
    ctl_o  = 8'h00;
    addr_o = 16'h0000;
    bank_o = 2'h0;
  end
  // One access: k picks the group, f the flags; returns after the answer edge.
  task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [2:0] f, input logic [1:0] bk);
    @(negedge clk_i);
    addr_o = a;
    bank_o = bk;
    ctl_o  = (k == 2'd0) ? {1'b1, f, 4'h0} : (k == 2'd1) ? {4'h0, 1'b1, f[0], 2'b00} : {6'h00, 1'b1, f[0]};
    @(negedge clk_i);
    ctl_o  = 8'h00;
    // A released address shows the inverse so stale values never match by luck.
    addr_o = ~a;
    bank_o = ~bk;
  endtask : acc
endmodule : mmsd_core_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the memory space decoder, 64k variant.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mmsd_pkg::*;
  typedef struct packed {
    logic [1:0] k; logic [15:0] a; logic [2:0] f; logic [1:0] bk; mmsd_target_t t; logic [15:0] e;
  } mmsd_row_t;
  logic clk_i, resetn_i;
  logic [7:0] ctl;
  logic [15:0] addr;
  logic [1:0] bank;
  wire logic id_req_i, id_indirect_i, id_bit_i, id_reg_i, xd_req_i, xd_usb_i, pm_req_i, pm_erase_i;
  wire logic [7:0] id_addr_i = addr[7:0];
  wire logic [15:0] xd_addr_i = addr;
  wire logic [15:0] pm_addr_i = addr;
  wire logic [1:0] psw_bank_i = bank;
  logic id_valid_o, id_bank_o, id_bitarea_o, xd_valid_o, pm_valid_o, pm_sector_erase_o;
  mmsd_target_t id_target_o, xd_target_o, pm_target_o;
  logic [7:0] id_ram_addr_o;
  logic [2:0] id_bit_o;
  logic [11:0] xd_ram_addr_o;
  logic [9:0] xd_fifo_addr_o;
  logic [15:0] pm_flash_addr_o;
  logic [6:0] pm_sector_o;
  int mismatches = 0;
  int n_checks = 0;
  // Outputs of the group that a table row exercised.
  mmsd_target_t sel_t;
  logic [15:0]  sel_a;
  logic         sel_v;
  assign {id_req_i, id_indirect_i, id_bit_i, id_reg_i, xd_req_i, xd_usb_i, pm_req_i, pm_erase_i} = ctl;
  mmsd_core_model u_core (.clk_i(clk_i), .ctl_o(ctl), .addr_o(addr), .bank_o(bank));
  mmsd_decoder #(.FLASH_64K(1'b1)) u_dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Ordinary cases; a refused access expects the previous address to hold.
  mmsd_row_t rows [16] = '{
    '{2'd0, 16'h0090, 3'b000, 2'd0, MMSD_T_SPECIAL_FUNCTION_REGISTER_SPACE, 16'h0090},
    '{2'd0, 16'h0090, 3'b100, 2'd0, MMSD_T_IRAM, 16'h0090},
    '{2'd0, 16'h0045, 3'b000, 2'd0, MMSD_T_IRAM, 16'h0045},
    '{2'd0, 16'h0045, 3'b100, 2'd0, MMSD_T_IRAM, 16'h0045},
    '{2'd0, 16'h0003, 3'b001, 2'd2, MMSD_T_IRAM, 16'h0013},
    '{2'd0, 16'h00f7, 3'b001, 2'd3, MMSD_T_IRAM, 16'h001f},
    '{2'd0, 16'h000b, 3'b010, 2'd0, MMSD_T_IRAM, 16'h0021},
    '{2'd0, 16'h007f, 3'b010, 2'd0, MMSD_T_IRAM, 16'h002f},
    '{2'd0, 16'h008b, 3'b010, 2'd0, MMSD_T_SPECIAL_FUNCTION_REGISTER_SPACE, 16'h0088},
    '{2'd0, 16'h00ff, 3'b100, 2'd0, MMSD_T_IRAM, 16'h00ff},
    '{2'd1, 16'h0fff, 3'b000, 2'd0, MMSD_T_ONCHIP_EXTERNAL_DATA_RAM, 16'h0fff},
    '{2'd1, 16'h1000, 3'b000, 2'd0, MMSD_T_NONE, 16'h0fff},
    '{2'd1, 16'h03ff, 3'b001, 2'd0, MMSD_T_USB_FIFO, 16'h03ff},
    '{2'd1, 16'h0400, 3'b001, 2'd0, MMSD_T_NONE, 16'h03ff},
    '{2'd2, 16'hfbff, 3'b000, 2'd0, MMSD_T_CODE, 16'hfbff},
    '{2'd2, 16'hfc00, 3'b000, 2'd0, MMSD_T_NONE, 16'hfbff}
  };
  // Clock at 4 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Main sequence: reset, table loop, then hand-written cases.
  initial begin
    resetn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("reset target", 16'(MMSD_T_NONE), 16'(id_target_o));
    chk("reset valid", 16'h0000, {15'h0000, id_valid_o | xd_valid_o | pm_valid_o});
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    foreach (rows[i]) begin
      u_core.acc(rows[i].k, rows[i].a, rows[i].f, rows[i].bk);
      sel_t = rows[i].k == 2'd0 ? id_target_o : rows[i].k == 2'd1 ? xd_target_o : pm_target_o;
      sel_a = rows[i].k == 2'd0 ? {8'h00, id_ram_addr_o} : rows[i].k == 2'd2 ? pm_flash_addr_o :
              rows[i].f[0] ? {6'h00, xd_fifo_addr_o} : {4'h0, xd_ram_addr_o};
      sel_v = rows[i].k == 2'd0 ? id_valid_o : rows[i].k == 2'd1 ? xd_valid_o : pm_valid_o;
      chk("target", 16'(rows[i].t), 16'(sel_t));
      chk("address", rows[i].e, sel_a);
      chk("valid", 16'h0001, {15'h0000, sel_v});
    end
    // Bit number and area flags, then bank flag.
    u_core.acc(2'd0, 16'h000b, 3'b010, 2'd0);
    chk("bit flags", 16'h0007, {12'h000, id_bit_o, id_bitarea_o});
    u_core.acc(2'd0, 16'h0005, 3'b001, 2'd3);
    chk("bank flag", 16'h011d, {7'h00, id_bank_o, id_ram_addr_o});
    // Sector erase flags one cycle only, and never inside the reserved top.
    u_core.acc(2'd2, 16'h0200, 3'b001, 2'd0);
    chk("sector", 16'h0003, {8'h00, pm_sector_o, pm_sector_erase_o});
    @(negedge clk_i);
    chk("erase drop", 16'h0000, {14'h0000, pm_sector_erase_o, pm_valid_o});
    // A reset in mid-run clears held addresses at once; requests wait out the release.
    resetn_i = 1'b0;
    @(negedge clk_i);
    chk("mid reset", 16'h0000, {pm_flash_addr_o[15:8], id_ram_addr_o});
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    u_core.acc(2'd2, 16'hfe00, 3'b001, 2'd0);
    chk("reserved erase", {13'h0000, MMSD_T_NONE}, {12'h000, pm_target_o, pm_sector_erase_o});
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
